// *** input_capture_unit.v ***
// Four-channel input capture unit with Avalon-MM register access.
`timescale 1ns/1ps
`include "icu_defs.vh"
module input_capture_unit #(
   parameter NUM_CH = 4,
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW = 2,
   parameter NUM_SYNC = 19
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Avalon-MM slave
   input wire [6:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output wire [31:0] readdata,
   output wire waitrequest,
   // Capture pins
   input wire [NUM_CH-1:0] capture_pin,
   // Timer clocks
   input wire timer_one_clock,
   input wire timer_two_clock,
   input wire timer_three_clock,
   input wire timer_four_clock,
   input wire timer_five_clock,
   // Sync and trigger sources
   input wire [NUM_SYNC-1:0] sync_sources,
   // Processor power state
   input wire cpu_idle,
   input wire cpu_sleep,
   // Interrupt requests
   output wire [NUM_CH-1:0] irq_out
);

   // ==========================================================================
   // Bus handshake
   // One wait cycle lets the read data come from a flop; side effects
   // happen only at the completing edge.
   reg ack_q;
   reg [31:0] readdata_q;
   reg [31:0] rd_mux;
   wire req;
   wire wr_go;
   wire rd_go;
   wire is_global;
   wire [1:0] ch_sel;
   wire [1:0] reg_sel;

   assign req = read | write;
   assign waitrequest = req & ~ack_q;
   assign wr_go = write & ack_q;
   assign rd_go = read & ack_q;
   assign readdata = readdata_q;
   assign is_global = address[`ADR_GLOBAL_BIT];
   assign ch_sel = address[`ADR_CH_HI:`ADR_CH_LO];
   assign reg_sel = address[`ADR_REG_HI:`ADR_REG_LO];

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
         readdata_q <= 32'h00000000;
      end else begin
         ack_q <= req & ~ack_q;
         if (read & ~ack_q) begin
            readdata_q <= rd_mux;
         end
      end
   end

   function [15:0] merge16;
      input [15:0] old_v;
      input [15:0] new_v;
      input [15:0] mask;
      input [1:0] be;
      reg [15:0] bm;
      begin
         bm = {{8{be[1]}}, {8{be[0]}}} & mask;
         merge16 = (old_v & ~bm) | (new_v & bm);
      end
   endfunction

   // ==========================================================================
   // Input synchronisers
   reg [NUM_CH-1:0] pin_s1_q;
   reg [NUM_CH-1:0] pin_s2_q;
   reg [NUM_CH-1:0] pin_s3_q;
   reg [4:0] tclk_s1_q;
   reg [4:0] tclk_s2_q;
   reg [4:0] tclk_s3_q;
   wire [NUM_CH-1:0] pin_rise;
   wire [NUM_CH-1:0] pin_fall;
   wire [4:0] tclk_edge;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= {NUM_CH{1'b0}};
         pin_s2_q <= {NUM_CH{1'b0}};
         pin_s3_q <= {NUM_CH{1'b0}};
         tclk_s1_q <= 5'h00;
         tclk_s2_q <= 5'h00;
         tclk_s3_q <= 5'h00;
      end else begin
         pin_s1_q <= capture_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         tclk_s1_q <= {timer_five_clock, timer_four_clock, timer_three_clock, timer_two_clock, timer_one_clock};
         tclk_s2_q <= tclk_s1_q;
         tclk_s3_q <= tclk_s2_q;
      end
   end

   assign pin_rise = pin_s2_q & ~pin_s3_q;
   assign pin_fall = ~pin_s2_q & pin_s3_q;
   // Timer clocks are slow and asynchronous, so each rising edge becomes one tick.
   assign tclk_edge = tclk_s2_q & ~tclk_s3_q;

   // ==========================================================================
   // Interrupt flags and enables
   reg [NUM_CH-1:0] flag_q;
   reg [NUM_CH-1:0] ien_q;
   wire [NUM_CH-1:0] irq_set;
   wire [NUM_CH-1:0] flag_clr;
   wire wr_flag;
   wire wr_ien;

   assign wr_flag = wr_go & (address == `ADR_FLAG) & byteenable[0];
   assign wr_ien = wr_go & (address == `ADR_IEN) & byteenable[0];
   assign flag_clr = wr_flag ? writedata[NUM_CH-1:0] : {NUM_CH{1'b0}};

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         flag_q <= {NUM_CH{1'b0}};
         ien_q <= {NUM_CH{1'b0}};
      end else begin
         flag_q <= (flag_q & ~flag_clr) | irq_set;
         if (wr_ien) begin
            ien_q <= writedata[NUM_CH-1:0];
         end
      end
   end

   assign irq_out = flag_q & ien_q;

   // ==========================================================================
   // Capture channels
   wire [NUM_CH*16-1:0] con1_rd;
   wire [NUM_CH*16-1:0] con2_rd;
   wire [NUM_CH*16-1:0] buf_rd;
   wire [NUM_CH*16-1:0] cnt_rd;
   wire [NUM_CH-1:0] tick_w;
   wire [NUM_CH-1:0] ev_w;
   wire [NUM_SYNC:0] sync_vec;

   assign sync_vec = {sync_sources, 1'b0};

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1) begin : chan
         reg [15:0] con1_q;
         reg [15:0] con2_q;
         reg [15:0] cnt_q;
         reg [3:0] pre_q;
         reg [1:0] ipc_q;
         reg ov_q;
         reg arm_q;
         reg own_tick;
         reg own_ev;
         wire [2:0] mode;
         wire [2:0] csel;
         wire [4:0] ssel;
         wire casc;
         wire tick;
         wire cap;
         wire off;
         wire halt;
         wire trig_mode;
         wire sync_hit;
         wire run;
         wire fire;
         wire wake_irq;
         wire sel_me;
         wire wr_con1;
         wire wr_con2;
         wire pop;
         wire full_n;
         wire not_empty;
         wire [15:0] head;
         wire [FIFO_AW:0] level;

         assign mode = con1_q[`F_MODE];
         assign csel = con1_q[`F_CLK_SEL];
         assign ssel = con2_q[`F_SYNC_SEL];
         assign trig_mode = con2_q[`B_TRIG_MODE];
         assign sel_me = ~is_global & (ch_sel == g);
         assign wr_con1 = wr_go & sel_me & (reg_sel == `REG_CON1);
         assign wr_con2 = wr_go & sel_me & (reg_sel == `REG_CON2);

         assign off = (mode == `MODE_OFF) | (mode == `MODE_UNUSED);
         assign halt = cpu_sleep | (con1_q[`B_IDLE_STOP] & cpu_idle);
         // Source select, code zero means none.
         assign sync_hit = (ssel != `SYNC_NONE) & (ssel <= NUM_SYNC) & sync_vec[ssel];

         always @* begin
            case (csel)
               `CLK_PERIPH: own_tick = 1'b1;
               `CLK_T1: own_tick = tclk_edge[0];
               `CLK_T2: own_tick = tclk_edge[1];
               `CLK_T3: own_tick = tclk_edge[2];
               `CLK_T4: own_tick = tclk_edge[3];
               `CLK_T5: own_tick = tclk_edge[4];
               default: own_tick = 1'b0;
            endcase
         end

         always @* begin
            case (mode)
               `MODE_BOTH: own_ev = pin_rise[g] | pin_fall[g];
               `MODE_FALL: own_ev = pin_fall[g];
               `MODE_RISE: own_ev = pin_rise[g];
               `MODE_PRE4: own_ev = pin_rise[g] & (pre_q == `PRE4_LAST);
               `MODE_PRE16: own_ev = pin_rise[g] & (pre_q == `PRE16_LAST);
               default: own_ev = 1'b0;
            endcase
            own_ev = own_ev & ~halt;
         end

         // Odd channel takes carry and events of its even partner.
         if (g % 2 == 1) begin : odd
            assign casc = con2_q[`B_CASCADE];
            assign tick = casc ? (tick_w[g-1] & (cnt_rd[(g-1)*16 +: 16] == `CNT_ALL_ONES)) : own_tick;
            assign cap = casc ? ev_w[g-1] : own_ev;
         end else begin : even
            assign casc = 1'b0;
            assign tick = own_tick;
            assign cap = own_ev;
         end

         assign run = (~off | casc) & ~halt & (~trig_mode | arm_q);
         assign tick_w[g] = run & tick;
         assign ev_w[g] = cap;

         // Every-edge mode interrupts on each capture.
         assign fire = cap & ((mode == `MODE_BOTH) | (ipc_q == con1_q[`F_PER_IRQ]));
         // Wake pin acts only in sleep or idle.
         assign wake_irq = (mode == `MODE_WAKE) & pin_rise[g] & (cpu_sleep | cpu_idle);
         assign irq_set[g] = fire | wake_irq;

         assign pop = rd_go & sel_me & (reg_sel == `REG_BUF) & not_empty;

         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               con1_q <= `CON1_RESET;
               con2_q <= `CON2_RESET;
               cnt_q <= `CNT_RESET;
               pre_q <= 4'h0;
               ipc_q <= 2'h0;
               ov_q <= 1'b0;
               arm_q <= 1'b0;
            end else begin
               if (wr_con1) begin
                  con1_q <= merge16(con1_q, writedata[15:0], `CON1_WMASK, byteenable[1:0]);
               end
               if (wr_con2) begin
                  con2_q <= merge16(con2_q, writedata[15:0], `CON2_WMASK, byteenable[1:0]);
               end
               // Trigger arms on source, software disarms; arming wins.
               if (trig_mode & sync_hit) begin
                  arm_q <= 1'b1;
               end else if (wr_con2 & byteenable[0] & ~writedata[`B_TRIG_ARMED]) begin
                  arm_q <= 1'b0;
               end
               if ((off & ~casc) | (trig_mode & ~arm_q) | (~trig_mode & sync_hit)) begin
                  cnt_q <= `CNT_RESET;
               end else if (tick_w[g]) begin
                  cnt_q <= cnt_q + 16'h0001;
               end
               if (off) begin
                  pre_q <= 4'h0;
               end else if (pin_rise[g] & ~halt & ((mode == `MODE_PRE4) | (mode == `MODE_PRE16))) begin
                  if ((mode == `MODE_PRE4) ? (pre_q == `PRE4_LAST) : (pre_q == `PRE16_LAST)) begin
                     pre_q <= 4'h0;
                  end else begin
                     pre_q <= pre_q + 4'h1;
                  end
               end
               if (off & ~casc) begin
                  ipc_q <= 2'h0;
               end else if (fire) begin
                  ipc_q <= 2'h0;
               end else if (cap) begin
                  ipc_q <= ipc_q + 2'h1;
               end
               // Overflow sticks until the buffer is emptied.
               if (off & ~casc) begin
                  ov_q <= 1'b0;
               end else if (cap & ~full_n) begin
                  ov_q <= 1'b1;
               end else if (pop & ~cap & (level == {{FIFO_AW{1'b0}}, 1'b1})) begin
                  ov_q <= 1'b0;
               end
            end
         end

         // Buffer of captured counter values; full buffer drops new data.
         capture_fifo #(
            .WIDTH(16),
            .DEPTH(FIFO_DEPTH),
            .AW(FIFO_AW)
         ) fifo_i (
            .sys_clk(sys_clk),
            .rst(rst),
            .clear(off & ~casc),
            .push_valid(cap),
            .push_data(cnt_q),
            .push_ready(full_n),
            .pop_valid(not_empty),
            .pop_ready(pop),
            .pop_data(head),
            .level(level)
         );

         assign con1_rd[g*16 +: 16] = (con1_q & `CON1_WMASK) | ({15'h0000, ov_q} << `B_OVF) |
                                      ({15'h0000, not_empty} << `B_BNE);
         assign con2_rd[g*16 +: 16] = (con2_q & ~(16'h0001 << `B_TRIG_ARMED)) | ({15'h0000, arm_q} << `B_TRIG_ARMED);
         assign buf_rd[g*16 +: 16] = not_empty ? head : 16'h0000;
         assign cnt_rd[g*16 +: 16] = cnt_q;
      end
   endgenerate

   // ==========================================================================
   // Read data selection
   // Unmapped addresses read as zero and ignore writes.
   always @* begin
      rd_mux = 32'h00000000;
      if (address == `ADR_FLAG) begin
         rd_mux[NUM_CH-1:0] = flag_q;
      end else if (address == `ADR_IEN) begin
         rd_mux[NUM_CH-1:0] = ien_q;
      end else if (~is_global && reg_sel == `REG_CON1) begin
         rd_mux[15:0] = con1_rd[ch_sel*16 +: 16];
      end else if (~is_global && reg_sel == `REG_CON2) begin
         rd_mux[15:0] = con2_rd[ch_sel*16 +: 16];
      end else if (~is_global && reg_sel == `REG_BUF) begin
         rd_mux[15:0] = buf_rd[ch_sel*16 +: 16];
      end else if (~is_global && reg_sel == `REG_TMR) begin
         rd_mux[15:0] = cnt_rd[ch_sel*16 +: 16];
      end
   end

endmodule

// *** icu_defs.vh ***
// Register map, field positions, mode codes and reset values of the input capture unit.
`ifndef ICU_DEFS_VH
`define ICU_DEFS_VH

// ==========================================================================
// Address decode (byte addresses, one 32-bit word per register)
`define ADR_GLOBAL_BIT 6
`define ADR_CH_HI 5
`define ADR_CH_LO 4
`define ADR_REG_HI 3
`define ADR_REG_LO 2
`define REG_CON1 2'h0
`define REG_CON2 2'h1
`define REG_BUF 2'h2
`define REG_TMR 2'h3
`define ADR_FLAG 7'h40
`define ADR_IEN 7'h44

// ==========================================================================
// Control one fields
`define B_IDLE_STOP 13
`define F_CLK_SEL 12:10
`define F_PER_IRQ 6:5
`define B_OVF 4
`define B_BNE 3
`define F_MODE 2:0
`define CON1_WMASK 16'h3c67
`define CON1_RESET 16'h0000

// ==========================================================================
// Control two fields
`define B_CASCADE 8
`define B_TRIG_MODE 7
`define B_TRIG_ARMED 6
`define F_SYNC_SEL 4:0
`define CON2_WMASK 16'h01bf
`define CON2_RESET 16'h0000

// ==========================================================================
// Capture mode codes
`define MODE_OFF 3'h0
`define MODE_BOTH 3'h1
`define MODE_FALL 3'h2
`define MODE_RISE 3'h3
`define MODE_PRE4 3'h4
`define MODE_PRE16 3'h5
`define MODE_UNUSED 3'h6
`define MODE_WAKE 3'h7

// ==========================================================================
// Counter clock select codes
`define CLK_T3 3'h0
`define CLK_T2 3'h1
`define CLK_T4 3'h2
`define CLK_T5 3'h3
`define CLK_T1 3'h4
`define CLK_PERIPH 3'h7

// ==========================================================================
// Counts and constants
`define PRE4_LAST 4'h3
`define PRE16_LAST 4'hf
`define CNT_ALL_ONES 16'hffff
`define CNT_RESET 16'h0000
`define SYNC_NONE 5'h00

`endif

// *** capture_fifo.v ***
// First-in first-out store for captured counter values.
`timescale 1ns/1ps
module capture_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   input wire clear,
   // Filling side
   input wire push_valid,
   input wire [WIDTH-1:0] push_data,
   output wire push_ready,
   // Draining side
   output wire pop_valid,
   input wire pop_ready,
   output wire [WIDTH-1:0] pop_data,
   output wire [AW:0] level
);

   // ==========================================================================
   // Storage and pointers
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] level_q;
   wire do_push;
   wire do_pop;
   localparam [AW:0] FULL_LEVEL = DEPTH;
   localparam [AW-1:0] PTR_ONE = 1;
   localparam [AW:0] LVL_ONE = 1;

   assign push_ready = (level_q != FULL_LEVEL);
   assign pop_valid = (level_q != {(AW+1){1'b0}});
   assign do_push = push_valid & push_ready;
   assign do_pop = pop_ready & pop_valid;
   assign pop_data = mem_q[rd_ptr_q];
   assign level = level_q;

   always @(posedge sys_clk) begin
      if (do_push) begin
         mem_q[wr_ptr_q] <= push_data;
      end
   end

   // Pointers wrap freely, so DEPTH must be a power of two.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         level_q <= {(AW+1){1'b0}};
      end else if (clear) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         level_q <= {(AW+1){1'b0}};
      end else begin
         if (do_push) begin
            wr_ptr_q <= wr_ptr_q + PTR_ONE;
         end
         if (do_pop) begin
            rd_ptr_q <= rd_ptr_q + PTR_ONE;
         end
         if (do_push & ~do_pop) begin
            level_q <= level_q + LVL_ONE;
         end else if (do_pop & ~do_push) begin
            level_q <= level_q - LVL_ONE;
         end
      end
   end

endmodule

// *** pin_source.sv ***
// Model of the external signals whose edges the capture unit timestamps.
`timescale 1ns/1ps
// ==========================================
// Pin driver
module pin_source #(
   parameter NUM_CH = 4,
   parameter HOLD = 4
) (
   // Clock
   input wire sys_clk,
   // Pins
   output logic [NUM_CH-1:0] capture_pin
);
   initial capture_pin = '0;
   // Each level is held long enough for the three-flop synchroniser to see it.
   task automatic drive(input int ch, input logic lvl);
      @(posedge sys_clk);
      capture_pin[ch] <= lvl;
      repeat (HOLD) @(posedge sys_clk);
   endtask
   task automatic pulse(input int ch);
      drive(ch, 1'b1);
      drive(ch, 1'b0);
   endtask
endmodule

// *** input_capture_unit_chk.sv ***
// Concurrent checks on the ports of the input capture unit.
`timescale 1ns/1ps
`include "icu_defs.vh"
// ==========================================
// Port checker
module input_capture_unit_chk #(
   parameter NUM_CH = 4
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Register bus
   input wire [6:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire [31:0] readdata,
   input wire waitrequest,
   // Interrupts
   input wire [NUM_CH-1:0] irq_out
);
   wire req = read | write;
   wire pend = req & waitrequest;
   wire done = req & ~waitrequest;
   wire con_rd = read & ~waitrequest & ~address[6] & (address[3:2] == `REG_CON1);
   reg [NUM_CH-1:0] ien_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Shadow of the enable register, so masking can be judged from the ports alone.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ien_q <= {NUM_CH{1'b0}};
      end else if (write && !waitrequest && address == `ADR_IEN && byteenable[0]) begin
         ien_q <= writedata[NUM_CH-1:0];
      end
   end
   a_wait_first: assert property (req && !$past(pend) |-> waitrequest)
      else $error("waitrequest low in first request cycle");
   a_wait_once: assert property (pend |=> !waitrequest)
      else $error("request not answered in second cycle");
   a_wait_idle: assert property (!req |-> !waitrequest)
      else $error("waitrequest high without a request");
   a_read_hold: assert property (!read |=> $stable(readdata))
      else $error("readdata changed without a read");
   a_upper_zero: assert property (readdata[31:16] == 16'h0000)
      else $error("readdata upper half not zero");
   a_unmapped_zero: assert property (read && !waitrequest && address[6] && address[5:3] != 3'h0 |->
      readdata == 32'h0)
      else $error("unmapped read not zero");
   a_con_reserved: assert property (con_rd |-> (readdata[15:0] & 16'hc380) == 16'h0000)
      else $error("reserved control bits read nonzero");
   a_ovf_not_empty: assert property (con_rd && readdata[4] |-> readdata[3])
      else $error("overflow shown with empty buffer");
   a_irq_masked: assert property ((irq_out & ~ien_q) == {NUM_CH{1'b0}})
      else $error("request forwarded while disabled");
   a_irq_sticky: assert property (|($past(irq_out) & ~irq_out) |-> $past(done) && $past(write))
      else $error("request dropped without a write");
   a_reset_quiet: assert property ($fell(rst) |-> irq_out == {NUM_CH{1'b0}} && readdata == 32'h0)
      else $error("outputs not quiet after reset");
endmodule
bind input_capture_unit input_capture_unit_chk #(.NUM_CH(NUM_CH)) i_input_capture_unit_chk (
   .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .irq_out(irq_out));

// *** input_capture_unit_tb.sv ***
// Self-checking testbench for the four-channel input capture unit.
`timescale 1ns/1ps
`include "icu_defs.vh"
// ==========================================
// Bench top
module input_capture_unit_tb;
   logic sys_clk, rst, read, write, tclk, cpu_idle, cpu_sleep;
   logic [6:0] address;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [18:0] sync_sources;
   wire [31:0] readdata;
   wire waitrequest;
   wire [3:0] irq_out, capture_pin;
   integer fail_count, comparisons, i, k, p, n;
   logic [15:0] st, v, last;
   logic [15:0] cnt_t [0:6] = '{0, 4, 4, 4, 1, 0, 0};
   logic [15:0] first_t [0:6] = '{0, 1, 2, 1, 7, 0, 0};
   logic [15:0] last_t [0:6] = '{0, 4, 8, 7, 7, 0, 0};
   // All timer inputs share one slow clock so each of the five timer select codes can be counted.
   input_capture_unit i_input_capture_unit (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .capture_pin(capture_pin), .timer_one_clock(tclk), .timer_two_clock(tclk),
      .timer_three_clock(tclk), .timer_four_clock(tclk), .timer_five_clock(tclk),
      .sync_sources(sync_sources), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq_out(irq_out));
   pin_source i_pin_source (.sys_clk(sys_clk), .capture_pin(capture_pin));
   function automatic [15:0] con(input idle, input [2:0] clk, input [1:0] per, input [2:0] mode);
      con = {2'b00, idle, clk, 3'b000, per, 2'b00, mode};
   endfunction
   task automatic chk(input [15:0] got, input [15:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Signals read right at a rising edge hold their values from before it, since the design updates
   // only by non-blocking assignment. Only the watchdog ends a wait that never completes.
   task automatic bus(input w, input [6:0] a, input [15:0] d, output [15:0] q);
      @(posedge sys_clk);
      address <= a;
      writedata <= {16'h0000, d};
      write <= w;
      read <= !w;
      @(posedge sys_clk);
      while (waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      q = readdata[15:0];
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input [6:0] a, input [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input [6:0] a, output [15:0] q);
      bus(1'b0, a, 16'h0000, q);
   endtask
   task automatic tick(input integer cnt);
      repeat (cnt) begin
         @(posedge sys_clk);
         tclk <= 1'b1;
         repeat (4) @(posedge sys_clk);
         tclk <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
   endtask
   task automatic irqchk(input logic e);
      @(negedge sys_clk);
      chk({15'h0000, irq_out[0]}, {15'h0000, e});
   endtask
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #300000;
      fail_count = fail_count + 1;
      $display("unexpected at %0t: watchdog expired", $time);
      summarize();
   end
   initial begin
      fail_count = 0;
      comparisons = 0;
      rst = 1'b1;
      {read, write, tclk, cpu_idle, cpu_sleep} = 5'h00;
      address = 7'h00;
      writedata = 32'h0;
      byteenable = 4'hf;
      sync_sources = 19'h00000;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         rd(7'(i * 16), v);
         chk(v, `CON1_RESET);
         rd(7'(i * 16 + 12), v);
         chk(v, `CNT_RESET);
      end
      wr(7'h10, 16'hffff);
      rd(7'h10, v);
      chk(v, `CON1_WMASK);
      wr(7'h10, 16'h0000);
      wr(7'h48, 16'h00ff);
      rd(7'h48, v);
      chk(v, 16'h0000);
      $display("test registers done");
      for (i = 0; i < 7; i = i + 1) begin
         wr(7'h00, con(1'b0, 3'(i), 2'b00, `MODE_OFF));
         wr(7'h00, con(1'b0, 3'(i), 2'b00, `MODE_RISE));
         tick(5);
         rd(7'h0c, v);
         chk(v, (i < 5) ? 16'h0005 : 16'h0000);
      end
      $display("test clock select done");
      for (i = 0; i < 7; i = i + 1) begin
         wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_OFF));
         wr(7'h00, con(1'b0, `CLK_T2, 2'b00, 3'(i)));
         for (p = 0; p < 4; p = p + 1) begin
            tick(1);
            i_pin_source.drive(0, 1'b1);
            tick(1);
            i_pin_source.drive(0, 1'b0);
         end
         rd(7'h00, st);
         chk(st[4], i == 1);
         n = 0;
         while (st[3] === 1'b1 && n < 8) begin
            rd(7'h08, v);
            if (n == 0) chk(v, first_t[i]);
            last = v;
            n = n + 1;
            rd(7'h00, st);
         end
         chk(16'(n), cnt_t[i]);
         if (n > 0) chk(last, last_t[i]);
         chk(st[4], 1'b0);
      end
      $display("test capture modes done");
      wr(`ADR_IEN, 16'h0001);
      for (k = 0; k < 4; k = k + 1) begin
         wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_OFF));
         wr(`ADR_FLAG, 16'h000f);
         wr(7'h00, con(1'b0, `CLK_T2, 2'(k), `MODE_RISE));
         for (p = 0; p <= k; p = p + 1) begin
            i_pin_source.pulse(0);
            irqchk(p == k);
         end
      end
      rd(`ADR_FLAG, v);
      chk(v, 16'h0001);
      wr(`ADR_FLAG, 16'h0001);
      wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_OFF));
      wr(7'h00, con(1'b0, `CLK_T2, 2'b11, `MODE_BOTH));
      i_pin_source.drive(0, 1'b1);
      irqchk(1'b1);
      wr(`ADR_IEN, 16'h0000);
      irqchk(1'b0);
      i_pin_source.drive(0, 1'b0);
      rd(`ADR_FLAG, v);
      chk(v, 16'h0001);
      wr(`ADR_FLAG, 16'h0001);
      rd(`ADR_FLAG, v);
      chk(v, 16'h0000);
      $display("test interrupts done");
      wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_OFF));
      wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_WAKE));
      i_pin_source.pulse(0);
      rd(`ADR_FLAG, v);
      chk(v, 16'h0000);
      @(posedge sys_clk);
      cpu_sleep <= 1'b1;
      i_pin_source.pulse(0);
      rd(`ADR_FLAG, v);
      chk(v, 16'h0001);
      rd(7'h00, v);
      chk(v & 16'h0018, 16'h0000);
      @(posedge sys_clk);
      cpu_sleep <= 1'b0;
      wr(`ADR_FLAG, 16'h0001);
      wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_OFF));
      @(posedge sys_clk);
      cpu_idle <= 1'b1;
      wr(7'h00, con(1'b1, `CLK_T2, 2'b00, `MODE_RISE));
      i_pin_source.pulse(0);
      rd(7'h00, v);
      chk(v[3], 1'b0);
      wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_RISE));
      i_pin_source.pulse(0);
      rd(7'h00, v);
      chk(v[3], 1'b1);
      @(posedge sys_clk);
      cpu_idle <= 1'b0;
      $display("test power states done");
      wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_OFF));
      wr(7'h04, 16'h0001);
      wr(7'h00, con(1'b0, `CLK_T2, 2'b00, `MODE_RISE));
      tick(3);
      rd(7'h0c, v);
      chk(v, 16'h0003);
      @(posedge sys_clk);
      sync_sources[0] <= 1'b1;
      @(posedge sys_clk);
      sync_sources[0] <= 1'b0;
      rd(7'h0c, v);
      chk(v, 16'h0000);
      wr(7'h04, 16'h0081);
      tick(2);
      rd(7'h0c, v);
      chk(v, 16'h0000);
      @(posedge sys_clk);
      sync_sources[0] <= 1'b1;
      @(posedge sys_clk);
      sync_sources[0] <= 1'b0;
      tick(2);
      rd(7'h0c, v);
      chk(v, 16'h0002);
      rd(7'h04, v);
      chk(v, 16'h00c1);
      wr(7'h04, 16'h0000);
      rd(7'h04, v);
      chk(v, 16'h0000);
      // Two back-to-back reads load the counter three clock edges apart.
      wr(7'h00, con(1'b0, `CLK_PERIPH, 2'b00, `MODE_RISE));
      rd(7'h0c, last);
      rd(7'h0c, v);
      chk(v - last, 16'h0003);
      wr(7'h14, 16'h0100);
      i_pin_source.pulse(0);
      rd(7'h10, v);
      chk(v[3], 1'b1);
      rd(7'h18, v);
      chk(v, 16'h0000);
      rd(7'h10, v);
      chk(v[3], 1'b0);
      $display("test sync and cascade done");
      summarize();
   end
endmodule
